/* design/axil_reg_slave.sv */
// axi4-lite slave that reaches the sleep control and status words
`timescale 1ns/1ps
module axil_reg_slave
    import sleep_pkg::*;
(
    input  logic              ref_clk,
    input  logic              rst_b,
    input  logic [ADDR_W-1:0] s_axi_awaddr,
    input  logic              s_axi_awvalid,
    output logic              s_axi_awready,
    input  logic [31:0]       s_axi_wdata,
    input  logic [3:0]        s_axi_wstrb,
    input  logic              s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  logic              s_axi_bready,
    input  logic [ADDR_W-1:0] s_axi_araddr,
    input  logic              s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  logic              s_axi_rready,
    reg_port_if.slave         regs
);
    typedef struct packed {
        logic              aw_got;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_got;
        logic [7:0]        w_byte;
        logic              w_lane0;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } axil_s;

    axil_s st_reg;
    axil_s st_next;
    logic  do_write;

    // channel readies: one write and one read outstanding at most
    assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
    assign s_axi_wready  = !st_reg.w_got && !st_reg.bvalid;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rresp;
    assign do_write      = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
    assign regs.ctrl_we  = do_write && st_reg.w_lane0
                           && st_reg.aw_addr == SLEEP_CONTROL_OFFSET;
    assign regs.ctrl_wdata = st_reg.w_byte;

    // address and data taken in either order, response after both
    always_comb
    begin
        st_next = st_reg;
        if (s_axi_awvalid && s_axi_awready)
        begin
            st_next.aw_got  = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            st_next.w_got   = 1'b1;
            st_next.w_byte  = s_axi_wdata[7:0];
            st_next.w_lane0 = s_axi_wstrb[0];
        end
        if (do_write)
        begin
            st_next.aw_got = 1'b0;
            st_next.w_got  = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp  = (st_reg.aw_addr == SLEEP_CONTROL_OFFSET ||
                              st_reg.aw_addr == SLEEP_STATUS_OFFSET)
                             ? RESP_OKAY : RESP_SLVERR;
        end
        if (st_reg.bvalid && s_axi_bready)
            st_next.bvalid = 1'b0;
        if (st_reg.rvalid && s_axi_rready)
            st_next.rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = RESP_OKAY;
            unique case (s_axi_araddr)
                SLEEP_CONTROL_OFFSET: st_next.rdata = {24'h0, regs.ctrl_rdata};
                SLEEP_STATUS_OFFSET:  st_next.rdata = {24'h0, regs.stat_rdata};
                default:
                begin
                    st_next.rdata = 32'h0;
                    st_next.rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end
endmodule // axil_reg_slave

/* design/reg_port_if.sv */
// register access path between the bus slave and the sleep core
`timescale 1ns/1ps
interface reg_port_if;
    logic       ctrl_we;
    logic [7:0] ctrl_wdata;
    logic [7:0] ctrl_rdata;
    logic [7:0] stat_rdata;

    modport slave
    (
        output ctrl_we,
        output ctrl_wdata,
        input  ctrl_rdata,
        input  stat_rdata
    );
    modport core
    (
        input  ctrl_we,
        input  ctrl_wdata,
        output ctrl_rdata,
        output stat_rdata
    );
endinterface

/* design/sleep_mode_controller.sv */
// sleep controller: mode register, sleep entry, clock gating, wake-up
//
// How it works
// - idle stops cpu, peripherals keep clocking
// - idle wakes on any enabled interrupt
// - standby clocks only peripherals set run_in_standby
// - power-down keeps brownout, supervision, periodic timer
// - power-down wakes on pin, timer, monitor, twi, logic
// - standby wakers need run_in_standby; others idle only
// - custom logic wakes power-down only without internal clock
// - wake waits six cycles plus oscillator start
// - idle wake adds no oscillator start delay
// - power-down stops clocks except ulp and rtc use
// - fuse code 0x3 extends wake until brownout ready
// - debug break wakes device without pending interrupt
// - mode codes: idle, standby, power-down, reserved
// - interrupt serviced then resumes after sleep instruction
`timescale 1ns/1ps
module sleep_mode_controller
    import sleep_pkg::*;
(
    input  logic                      ref_clk,
    input  logic                      rst_b,
    // ****************************************************************
    // axi4-lite register port
    // ****************************************************************
    input  logic [sleep_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  logic                      s_axi_awvalid,
    output logic                      s_axi_awready,
    input  logic [31:0]               s_axi_wdata,
    input  logic [3:0]                s_axi_wstrb,
    input  logic                      s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  logic                      s_axi_bready,
    input  logic [sleep_pkg::ADDR_W-1:0] s_axi_araddr,
    input  logic                      s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  logic                      s_axi_rready,
    // ****************************************************************
    // cpu, debug and wake sources
    // ****************************************************************
    input  logic                      sleep_instr,
    input  logic                      debug_break,
    input  logic                      other_irq,
    input  logic                      pin_change_irq,
    input  logic                      pit_irq,
    input  logic                      vlm_irq,
    input  logic                      twi_match_irq,
    input  sleep_pkg::sb_vec_t        standby_irq,
    input  sleep_pkg::sb_vec_t        run_in_standby,
    input  logic                      ccl_no_int_clk,
    // ****************************************************************
    // clock sources and brownout detector
    // ****************************************************************
    input  logic                      main_osc_run_standby,
    input  logic                      main_osc_ready,
    input  logic                      ulp_in_use,
    input  logic                      rtc_clk_in_use,
    input  logic [1:0]                bod_active_fuse,
    input  logic                      bod_ready,
    // ****************************************************************
    // clock gates and status
    // ****************************************************************
    output logic                      cpu_clk_en,
    output logic                      per_clk_en,
    output sleep_pkg::sb_vec_t        standby_clk_en,
    output logic                      always_on_clk_en,
    output logic                      main_osc_en,
    output logic                      ulp_osc_en,
    output logic                      rtc_osc_en,
    output logic                      sleeping
);
    import sleep_pkg::*;

    typedef struct packed {
        sleep_state_e st;
        logic         arm;
        logic [1:0]   mode;
        logic [1:0]   slept_mode;
    } core_s;

    core_s      st_reg;
    core_s      st_next;
    logic       enter_ok;
    logic       idle_wake;
    logic       standby_wake;
    logic       power_down_mode_wake;
    logic       wake_now;
    logic       wake_start;
    logic       wake_need_osc;
    logic       wake_done;
    logic       run_all;
    reg_port_if regs ();

    // ****************************************************************
    // register access
    // ****************************************************************
    axil_reg_slave u_bus
    (
        .ref_clk       (ref_clk),
        .rst_b         (rst_b),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .regs          (regs)
    );

    // control word: upper bits read zero, status shows state and mode
    assign regs.ctrl_rdata = {5'h00, st_reg.mode, st_reg.arm};
    assign regs.stat_rdata = {3'h0, st_reg.slept_mode,
                              st_reg.st == ST_WAKE, sleeping, 1'b0};

    // ****************************************************************
    // wake source qualification
    // ****************************************************************
    assign idle_wake     = other_irq | (|standby_irq) | pin_change_irq
                           | pit_irq | vlm_irq | twi_match_irq;
    assign standby_wake  = (|(standby_irq & run_in_standby))
                           | pin_change_irq | pit_irq | vlm_irq
                           | twi_match_irq;
    assign power_down_mode_wake    = pin_change_irq | pit_irq | vlm_irq
                           | twi_match_irq
                           | (standby_irq[SB_CCL] & ccl_no_int_clk);
    assign enter_ok      = sleep_instr && st_reg.arm
                           && st_reg.mode != MODE_RESERVED;

    // chosen wake condition for the current sleep state
    always_comb
    begin
        wake_now = 1'b0;
        unique case (st_reg.st)
            ST_IDLE:    wake_now = idle_wake | debug_break;
            ST_STANDBY: wake_now = standby_wake | debug_break;
            ST_POWER_DOWN_MODE:   wake_now = power_down_mode_wake | debug_break;
            ST_ACTIVE,
            ST_WAKE:    wake_now = 1'b0;
            default:    wake_now = 1'b0;
        endcase
    end

    assign wake_start    = sleeping && wake_now;
    assign wake_need_osc = st_reg.st == ST_POWER_DOWN_MODE
                           || (st_reg.st == ST_STANDBY
                               && !main_osc_run_standby);

    wake_timer u_wake
    (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .start     (wake_start),
        .need_osc  (wake_need_osc),
        .osc_ready (main_osc_ready),
        .bod_wait  (bod_active_fuse == BOD_WAIT_CODE),
        .bod_ready (bod_ready),
        .done      (wake_done)
    );

    // ****************************************************************
    // sleep sequencing
    // ****************************************************************
    always_comb
    begin
        st_next = st_reg;
        if (regs.ctrl_we)
        begin
            st_next.arm  = regs.ctrl_wdata[ARM_BIT];
            st_next.mode = regs.ctrl_wdata[MODE_LSB +: 2];
        end
        unique case (st_reg.st)
            ST_ACTIVE:
            begin
                if (enter_ok)
                begin
                    st_next.slept_mode = st_reg.mode;
                    unique case (st_reg.mode)
                        MODE_IDLE:       st_next.st = ST_IDLE;
                        MODE_STANDBY:    st_next.st = ST_STANDBY;
                        MODE_POWER_DOWN: st_next.st = ST_POWER_DOWN_MODE;
                        default:         st_next.st = ST_ACTIVE;
                    endcase
                end
            end
            ST_IDLE,
            ST_STANDBY,
            ST_POWER_DOWN_MODE:
            begin
                if (wake_now)
                    st_next.st = ST_WAKE;
            end
            ST_WAKE:
            begin
                // pending request stays with the cpu to service
                if (wake_done)
                    st_next.st = ST_ACTIVE;
            end
            default: st_next.st = ST_ACTIVE;
        endcase
    end

    // state register; any reset returns to active
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_reg      <= '0;
            st_reg.st   <= ST_ACTIVE;
            st_reg.arm  <= SLEEP_CONTROL_RESET[ARM_BIT];
            st_reg.mode <= SLEEP_CONTROL_RESET[MODE_LSB +: 2];
        end
        else
            st_reg <= st_next;
    end

    // ****************************************************************
    // clock gating
    // ****************************************************************
    assign sleeping   = st_reg.st == ST_IDLE || st_reg.st == ST_STANDBY
                        || st_reg.st == ST_POWER_DOWN_MODE;
    assign run_all    = st_reg.st == ST_ACTIVE || st_reg.st == ST_IDLE
                        || st_reg.st == ST_WAKE;
    assign cpu_clk_en = st_reg.st == ST_ACTIVE;
    assign per_clk_en = run_all;
    assign always_on_clk_en = 1'b1;
    assign main_osc_en = run_all || (st_reg.st == ST_STANDBY
                                     && main_osc_run_standby);
    assign ulp_osc_en = st_reg.st != ST_POWER_DOWN_MODE || ulp_in_use;
    assign rtc_osc_en = run_all || rtc_clk_in_use
                        || (st_reg.st == ST_STANDBY && run_in_standby[SB_RTC]);

    // per-peripheral gates honour run_in_standby in standby
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SB; gi++)
        begin : g_sb
            assign standby_clk_en[gi] = run_all
                || (st_reg.st == ST_STANDBY && run_in_standby[gi]);
        end
    endgenerate

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    property p_idle_gate;
        st_reg.st == ST_IDLE |-> !cpu_clk_en && per_clk_en;
    endproperty
    a_idle_gate: assert property (p_idle_gate)
        else $error("idle gating wrong");

    property p_idle_wake;
        st_reg.st == ST_IDLE && other_irq |=> st_reg.st == ST_WAKE;
    endproperty
    a_idle_wake: assert property (p_idle_wake)
        else $error("idle did not wake on interrupt");

    property p_standby_gate;
        st_reg.st == ST_STANDBY |-> standby_clk_en == run_in_standby
                                    && !per_clk_en;
    endproperty
    a_standby_gate: assert property (p_standby_gate)
        else $error("standby gating wrong");

    property p_power_down_mode_gate;
        st_reg.st == ST_POWER_DOWN_MODE |-> always_on_clk_en && !per_clk_en
                                  && !cpu_clk_en && !main_osc_en
                                  && ulp_osc_en == ulp_in_use;
    endproperty
    a_power_down_mode_gate: assert property (p_power_down_mode_gate)
        else $error("power-down gating wrong");

    property p_power_down_mode_stay;
        st_reg.st == ST_POWER_DOWN_MODE && !debug_break && !power_down_mode_wake
        |=> st_reg.st == ST_POWER_DOWN_MODE;
    endproperty
    a_power_down_mode_stay: assert property (p_power_down_mode_stay)
        else $error("power-down left without allowed source");

    property p_standby_mask;
        st_reg.st == ST_STANDBY && !debug_break && !standby_wake
        |=> st_reg.st == ST_STANDBY;
    endproperty
    a_standby_mask: assert property (p_standby_mask)
        else $error("standby left without allowed source");

    property p_break_wake;
        sleeping && debug_break |=> st_reg.st == ST_WAKE ##1 !cpu_clk_en;
    endproperty
    a_break_wake: assert property (p_break_wake)
        else $error("debug break did not wake");

    property p_ignore_sleep;
        st_reg.st == ST_ACTIVE && sleep_instr
        && (!st_reg.arm || st_reg.mode == MODE_RESERVED)
        |=> st_reg.st == ST_ACTIVE;
    endproperty
    a_ignore_sleep: assert property (p_ignore_sleep)
        else $error("sleep entered while not armed");

    property p_enter_mode;
        st_reg.st == ST_ACTIVE && enter_ok && st_reg.mode == MODE_STANDBY
        |=> st_reg.st == ST_STANDBY;
    endproperty
    a_enter_mode: assert property (p_enter_mode)
        else $error("mode code decoded wrong");

    property p_ctrl_zero;
        regs.ctrl_we
        |=> regs.ctrl_rdata == ($past(regs.ctrl_wdata) & 8'h07);
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero)
        else $error("control upper bits not zero");
endmodule // sleep_mode_controller

/* design/sleep_pkg.sv */
// constants and types shared by the sleep controller files
package sleep_pkg;

    // ****************************************************************
    // register map and fields
    // ****************************************************************
    localparam int         ADDR_W              = 8;
    localparam logic [7:0] SLEEP_CONTROL_OFFSET = 8'h00;
    localparam logic [7:0] SLEEP_STATUS_OFFSET  = 8'h04;
    localparam int         ARM_BIT              = 0;
    localparam int         MODE_LSB             = 1;
    localparam logic [7:0] SLEEP_CONTROL_RESET  = 8'h00;
    localparam logic [1:0] RESP_OKAY            = 2'h0;
    localparam logic [1:0] RESP_SLVERR          = 2'h2;

    // ****************************************************************
    // sleep mode codes and wake timing
    // ****************************************************************
    localparam logic [1:0] MODE_IDLE       = 2'h0;
    localparam logic [1:0] MODE_STANDBY    = 2'h1;
    localparam logic [1:0] MODE_POWER_DOWN = 2'h2;
    localparam logic [1:0] MODE_RESERVED   = 2'h3;
    localparam logic [2:0] WAKE_CYCLES     = 3'h6;
    localparam logic [1:0] BOD_WAIT_CODE   = 2'h3;

    // ****************************************************************
    // standby-capable peripherals, one bit each
    // ****************************************************************
    localparam int NUM_SB = 6;
    localparam int SB_RTC = 0;
    localparam int SB_CCL = 1;
    localparam int SB_ADC = 2;
    localparam int SB_TCB = 3;
    localparam int SB_SOF = 4;
    localparam int SB_AC  = 5;
    typedef logic [NUM_SB-1:0] sb_vec_t;

    typedef enum logic [2:0] {
        ST_ACTIVE,
        ST_IDLE,
        ST_STANDBY,
        ST_POWER_DOWN_MODE,
        ST_WAKE
    } sleep_state_e;

endpackage

/* design/wake_timer.sv */
// counts the wake-up delay: oscillator start, six cycles, brownout ready
`timescale 1ns/1ps
module wake_timer
    import sleep_pkg::*;
(
    input  logic ref_clk,
    input  logic rst_b,
    input  logic start,
    input  logic need_osc,
    input  logic osc_ready,
    input  logic bod_wait,
    input  logic bod_ready,
    output logic done
);
    typedef struct packed {
        logic       busy;
        logic       osc_ok;
        logic [2:0] cnt;
    } wake_s;

    wake_s st_reg;
    wake_s st_next;

    // finished when six cycles passed and the detector is ready if asked
    assign done = st_reg.busy && st_reg.cnt == WAKE_CYCLES
                  && (!bod_wait || bod_ready);

    // count starts once the main clock source runs
    always_comb
    begin
        st_next = st_reg;
        if (start)
        begin
            st_next.busy   = 1'b1;
            st_next.osc_ok = !need_osc;
            st_next.cnt    = 3'h0;
        end
        else if (st_reg.busy)
        begin
            if (!st_reg.osc_ok && osc_ready)
                st_next.osc_ok = 1'b1;
            if (st_reg.osc_ok && st_reg.cnt != WAKE_CYCLES)
                st_next.cnt = st_reg.cnt + 3'h1;
            if (done)
                st_next.busy = 1'b0;
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    property p_six_cycles;
        start && !need_osc && !bod_wait |=> !done [*6] ##1 done;
    endproperty
    a_six_cycles: assert property (p_six_cycles)
        else $error("wake delay is not six cycles");

    property p_bod_hold;
        bod_wait && !bod_ready |-> !done;
    endproperty
    a_bod_hold: assert property (p_bod_hold)
        else $error("wake ended before brownout ready");
endmodule // wake_timer

/* tb/cpu_model.sv */
// cpu stand-in issuing the sleep instruction
`timescale 1ns/1ps
module cpu_model
(input logic ref_clk, go, cpu_clk_en, output logic sleep_instr);
    // one pulse per request, only while the cpu clock runs
    always @(posedge ref_clk) sleep_instr <= go & cpu_clk_en;
endmodule // cpu_model

/* tb/tb.sv */
// self-checking bench for the sleep controller
`timescale 1ns/1ps
module tb;
    import sleep_pkg::*;
    logic ref_clk = 0, rst_b = 0, go = 0, s_axi_bready = 0, s_axi_rready = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, pit_irq = 0;
    logic debug_break = 0, other_irq = 0, pin_change_irq = 0, vlm_irq = 0;
    logic twi_match_irq = 0, ccl_no_int_clk = 0, ulp_in_use = 0, bod_ready = 1;
    logic main_osc_run_standby = 0, rtc_clk_in_use = 0, main_osc_ready = 1;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, bod_active_fuse = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, sleep_instr, cpu_clk_en, per_clk_en, sleeping;
    logic always_on_clk_en, main_osc_en, ulp_osc_en, rtc_osc_en;
    sb_vec_t standby_irq = 0, run_in_standby = 0, standby_clk_en;
    int err_total = 0, samples_checked = 0, n;
    always #2 ref_clk = ~ref_clk;
    cpu_model cpu_model_i (.ref_clk, .go, .cpu_clk_en, .sleep_instr);
    sleep_mode_controller sleep_mode_controller_i (.*);
    task automatic chk(input logic [31:0] s, e);
        samples_checked++;
        err_total += int'(s !== e);
        if (s !== e) $display("wrong value t=%0t %h %h", $time, s, e);
    endtask
    task automatic summarize();
        if (err_total == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // one bus write (w=1) or read, held until each channel is taken
    task automatic bus(input logic w, logic [7:0] a, logic [31:0] v);
        logic [3:0] t = 0;
        @(posedge ref_clk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, v};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        while (!t[3])
        begin
            @(negedge ref_clk);
            t = {s_axi_bvalid | s_axi_rvalid, s_axi_awready, s_axi_wready,
                 s_axi_arready};
            {d, r} = {s_axi_rdata, s_axi_bvalid ? s_axi_bresp : s_axi_rresp};
            @(posedge ref_clk);
            s_axi_awvalid <= s_axi_awvalid & !t[2];
            s_axi_wvalid <= s_axi_wvalid & !t[1];
            s_axi_arvalid <= s_axi_arvalid & !t[0];
        end
        {s_axi_bready, s_axi_rready} <= 0;
    endtask
    task automatic slp(input logic [7:0] c);
        bus(1, SLEEP_CONTROL_OFFSET, {24'h0, c});
        go <= 1;
        @(posedge ref_clk) go <= 0;
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic wk();
        for (n = 0; n < 60 && cpu_clk_en !== 1'b1; n++) @(negedge ref_clk);
    endtask
    task automatic t_reg();
        bus(0, SLEEP_CONTROL_OFFSET, 0);
        chk(d, SLEEP_CONTROL_RESET);
        bus(1, SLEEP_CONTROL_OFFSET, 32'hFF);
        chk(r, RESP_OKAY);
        bus(0, SLEEP_CONTROL_OFFSET, 0);
        chk(d, 32'h07);
        bus(0, 8'h40, 0);
        chk(r, RESP_SLVERR);
    endtask
    task automatic t_idle();
        slp(8'h07);
        chk(sleeping, 0);
        slp({5'h0, MODE_IDLE, 1'b1});
        chk({sleeping, cpu_clk_en, per_clk_en}, 3'b101);
        @(posedge ref_clk) other_irq <= 1;
        wk();
        chk(n, 9);
        @(posedge ref_clk) other_irq <= 0;
    endtask
    // reset while in power-down returns to active with control cleared
    task automatic t_rst();
        slp({5'h0, MODE_POWER_DOWN, 1'b1});
        chk(sleeping, 1);
        @(posedge ref_clk) rst_b <= 0;
        @(posedge ref_clk) rst_b <= 1;
        @(negedge ref_clk);
        chk({sleeping, cpu_clk_en}, 2'b01);
        bus(0, SLEEP_CONTROL_OFFSET, 0);
        chk(d, SLEEP_CONTROL_RESET);
    endtask
    // wake held until the brownout detector reports ready
    task automatic t_bod();
        {bod_active_fuse, bod_ready} <= {BOD_WAIT_CODE, 1'b0};
        slp({5'h0, MODE_IDLE, 1'b1});
        @(posedge ref_clk) other_irq <= 1;
        repeat (12) @(negedge ref_clk);
        chk(cpu_clk_en, 0);
        @(posedge ref_clk) {other_irq, bod_ready} <= 2'b01;
        wk();
        chk(n, 2);
    endtask
    task automatic t_low();
        @(posedge ref_clk) ulp_in_use <= 1;
        slp({5'h0, MODE_POWER_DOWN, 1'b1});
        chk({per_clk_en, always_on_clk_en}, 2'b01);
        chk({main_osc_en, ulp_osc_en, rtc_osc_en}, 3'b010);
        @(posedge ref_clk) {other_irq, standby_irq} <= {1'b1, 6'h02};
        repeat (12) @(negedge ref_clk);
        chk(sleeping, 1);
        @(posedge ref_clk) pin_change_irq <= 1;
        wk();
        chk(cpu_clk_en, 1);
        chk(n, 10);
        @(posedge ref_clk) pin_change_irq <= 0;
        run_in_standby <= 6'h05;
        slp({5'h0, MODE_STANDBY, 1'b1});
        chk(standby_clk_en, 6'h05);
        chk(sleeping, 1);
        @(posedge ref_clk) debug_break <= 1;
        wk();
        chk(cpu_clk_en, 1);
    endtask
    initial
    begin
        repeat (12) @(posedge ref_clk);
        rst_b <= 1;
        t_reg();
        t_idle();
        t_rst();
        t_bod();
        t_low();
        summarize();
    end
    // watchdog against a hung handshake
    initial
    begin
        #50000 err_total++;
        summarize();
    end
endmodule // tb
